// ---- dv/ring_entry_builder.sv ----
// host software model that places ring entries before the decoder
`timescale 1ns/1ns
module ring_entry_builder (
    input wire logic mclk_i,
    input wire logic go_i,
    input wire logic bad_i,
    input wire logic [31:0] ctrl_i,
    input wire logic [31:0] len_i,
    input wire logic [63:0] ptr_i,
    output logic dw_valid_o,
    output logic [31:0] ctrl_o,
    output logic [31:0] len_o,
    output logic [63:0] ptr_o
);
    import isoch_decode_pkg::*;
    initial begin
        {dw_valid_o, ctrl_o, len_o, ptr_o} = '0;
    end
    always @(posedge mclk_i) begin
        dw_valid_o <= go_i;
        if (go_i) begin
            ctrl_o <= bad_i ? ctrl_i : {ctrl_i[31:16], ISOCH_TYPE, ctrl_i[9:0]};
            len_o <= {15'h0, len_i[LEN_HI:0]};
            ptr_o <= ptr_i;
        end else begin
            {ctrl_o, len_o, ptr_o} <= ~{ctrl_o, len_o, ptr_o};
        end
    end
endmodule : ring_entry_builder

// ---- dv/tb_isoch_transfer_descriptor_decode.sv ----
// random and corner stimulus for the descriptor decoder
`timescale 1ns/1ns
module tb_isoch_transfer_descriptor_decode;
    import isoch_decode_pkg::*;
    logic mclk, rst_b, go, bad, ext, sen, scap, cfg, xd, rwr, rrd, dwv;
    logic [31:0] ctrl, len, rwd, cdw, ldw, rdata;
    logic [63:0] ptr, pdw, idata;
    logic [13:0] mfi;
    logic [16:0] bytes, xlen;
    logic [1:0] ra, bur;
    logic irq, cyc, evn, spn, ns, ch, tde, cn, inl, last, sup, tok, asap, start, ev, evs, evi, ret;
    logic [3:0] ilen, lbp;
    logic [5:0] typ;
    logic [10:0] frm;
    int fail_count, n_tests;
    ring_entry_builder u_host (.mclk_i(mclk), .go_i(go), .bad_i(bad), .ctrl_i(ctrl), .len_i(len), .ptr_i(ptr),
        .dw_valid_o(dwv), .ctrl_o(cdw), .len_o(ldw), .ptr_o(pdw));
    isoch_transfer_descriptor_decode u_dut (.MCLK_I(mclk), .RST_B_I(rst_b), .DW_VALID_I(dwv), .CTRL_DW_I(cdw),
        .LEN_DW_I(ldw), .PTR_I(pdw), .EXT_COUNT_EN_I(ext), .STATUS_EN_I(sen), .STATUS_CAP_I(scap),
        .CFG_NOSNOOP_EN_I(cfg), .MICROFRAME_INDEX_REG_I(mfi), .XFER_DONE_I(xd), .BYTES_DONE_I(bytes), .REG_ADDR_I(ra),
        .REG_WDATA_I(rwd), .REG_WR_I(rwr), .REG_RD_I(rrd), .REG_RDATA_O(rdata), .IRQ_O(irq), .CYCLE_O(cyc),
        .EVAL_NEXT_O(evn), .SHORT_NOTIFY_O(spn), .NOSNOOP_O(ns), .CHAIN_O(ch), .TD_END_O(tde),
        .COMPL_NOTIFY_O(cn), .INLINE_O(inl), .INLINE_DATA_O(idata), .INLINE_LEN_O(ilen), .BURSTS_M1_O(bur),
        .LAST_ENTRY_O(last), .SUPPRESS_IRQ_O(sup), .TYPE_O(typ), .TYPE_OK_O(tok), .LAST_BURST_M1_O(lbp),
        .FRAME_O(frm), .ASAP_O(asap), .XFER_LEN_O(xlen), .START_O(start), .EVENT_O(ev), .EVENT_SHORT_O(evs),
        .EVENT_IRQ_O(evi), .RETIRE_O(ret));
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge mclk);
        {ra, rwd, rwr} <= {a, d, 1'b1};
        @(posedge mclk);
        rwr <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [31:0] e);
        @(posedge mclk);
        {ra, rrd} <= {a, 1'b1};
        @(posedge mclk);
        rrd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd
    task automatic run(input logic [31:0] c, input logic [16:0] l, input logic [63:0] p, input logic [16:0] b,
        input logic bd);
        logic sh, e;
        int k;
        sh = b < l;
        e = c[5] | (c[2] & sh);
        @(posedge mclk);
        {go, bad, ctrl, len, ptr, mfi} <= {1'b1, bd, c, 15'h0, l, p, ~c[30:20], 3'h0};
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        #1;
        chk({cyc, evn, spn, ns, ch}, {c[0], c[1], c[2], c[3] & cfg, c[4]});
        chk({tde, cn, sup, asap}, {~c[4], c[5], c[9], c[31]});
        chk(idata, c[6] ? p : 64'h0);
        chk({inl, ilen}, {c[6], c[6] ? l[3:0] : 4'h0});
        chk({bur, last, lbp}, {ext ? 2'h0 : c[8:7], sen & scap & (c[8:7] == 2'h1), c[19:16]});
        chk({typ, tok}, {bd ? c[15:10] : ISOCH_TYPE, !bd || c[15:10] == ISOCH_TYPE});
        chk({frm, xlen}, {c[30:20], l});
        @(posedge mclk);
        #1;
        chk(start, c[31]);
        mfi <= {c[30:20], 3'($urandom)};
        for (k = 0; k < 4 && start !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        chk(start, 1'b1);
        if (start !== 1'b1) results();
        {xd, bytes} <= {1'b1, b};
        @(posedge mclk);
        xd <= 1'b0;
        #1;
        chk({ev, evs, evi, ret}, {e, sh & e, (c[5] & ~c[9]) | (c[2] & sh), 1'b1});
        @(posedge mclk);
        #1;
        chk({ev, ret}, 2'h0);
        $display("transfer done, comparisons %0d", n_tests);
    endtask : run
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #400000;
        fail_count++;
        results();
    end
    initial begin
        logic [31:0] c;
        logic [16:0] l;
        {rst_b, go, bad, ext, sen, scap, cfg, xd, rwr, rrd, ctrl, len, rwd, ptr, mfi, bytes, ra} = '0;
        fail_count = 0;
        n_tests = 0;
        void'($urandom(32'hE425));
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        cfg <= 1'b1;
        run(32'h80000024, 17'h10, {$urandom, $urandom}, 17'h4, 1'b0);
        rd(ADDR_STATUS, 32'h3);
        chk(irq, 1'b0);
        wr(ADDR_MASK, 32'h3);
        chk(irq, 1'b1);
        rd(ADDR_MASK, 32'h3);
        rd(ADDR_STATE, 32'h80001424);
        rd(2'h3, 32'h0);
        wr(ADDR_STATUS, 32'h3);
        chk(irq, 1'b0);
        run(32'h0, LEN_MAX, 64'h0, LEN_MAX, 1'b1);
        rd(ADDR_STATUS, 32'h6);
        wr(ADDR_STATUS, 32'h6);
        repeat (30) begin
            {ext, sen, scap, cfg} <= 4'($urandom);
            c = $urandom;
            l = c[6] ? 17'($urandom_range(8, 0)) : 17'($urandom_range(32'h10000, 0));
            run(c, l, {$urandom, $urandom}, c[22] ? l : 17'($urandom_range(l, 0)), 1'b0);
        end
        results();
    end
endmodule : tb_isoch_transfer_descriptor_decode

// ---- logic/isoch_decode_pkg.sv ----
// constants and types for the isochronous descriptor control dword decoder
package isoch_decode_pkg;
    localparam int CYCLE_BIT = 0;
    localparam int EVAL_BIT = 1;
    localparam int SPN_BIT = 2;
    localparam int SNOOP_BIT = 3;
    localparam int CHAIN_BIT = 4;
    localparam int CN_BIT = 5;
    localparam int INLINE_BIT = 6;
    localparam int BURST_LO = 7;
    localparam int BURST_HI = 8;
    localparam int SUPP_BIT = 9;
    localparam int TYPE_LO = 10;
    localparam int TYPE_HI = 15;
    localparam int LBP_LO = 16;
    localparam int LBP_HI = 19;
    localparam int FRAME_LO = 20;
    localparam int FRAME_HI = 30;
    localparam int ASAP_BIT = 31;
    localparam int LEN_HI = 16;
    localparam int MFI_LO = 3;
    localparam int MFI_HI = 13;
    localparam int INLINE_MAX = 8;
    localparam logic [5:0] ISOCH_TYPE = 6'h05;
    localparam logic [1:0] LAST_ENTRY_MARK = 2'h1;
    localparam logic [16:0] LEN_MAX = 17'h10000;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam int IRQ_SHORT = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_BAD = 2;
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_MASK = 2'h1;
    localparam logic [1:0] ADDR_STATE = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} sched_t;
endpackage : isoch_decode_pkg

// ---- logic/isoch_transfer_descriptor_decode.sv ----
// isochronous descriptor control dword decoder with scheduler and event logic
`timescale 1ns/1ns
module isoch_transfer_descriptor_decode (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic DW_VALID_I,
    input wire logic [31:0] CTRL_DW_I,
    input wire logic [31:0] LEN_DW_I,
    input wire logic [63:0] PTR_I,
    input wire logic EXT_COUNT_EN_I,
    input wire logic STATUS_EN_I,
    input wire logic STATUS_CAP_I,
    input wire logic CFG_NOSNOOP_EN_I,
    input wire logic [13:0] MICROFRAME_INDEX_REG_I,
    input wire logic XFER_DONE_I,
    input wire logic [16:0] BYTES_DONE_I,
    input wire logic [1:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    output logic IRQ_O,
    output logic CYCLE_O,
    output logic EVAL_NEXT_O,
    output logic SHORT_NOTIFY_O,
    output logic NOSNOOP_O,
    output logic CHAIN_O,
    output logic TD_END_O,
    output logic COMPL_NOTIFY_O,
    output logic INLINE_O,
    output logic [63:0] INLINE_DATA_O,
    output logic [3:0] INLINE_LEN_O,
    output logic [1:0] BURSTS_M1_O,
    output logic LAST_ENTRY_O,
    output logic SUPPRESS_IRQ_O,
    output logic [5:0] TYPE_O,
    output logic TYPE_OK_O,
    output logic [3:0] LAST_BURST_M1_O,
    output logic [10:0] FRAME_O,
    output logic ASAP_O,
    output logic [16:0] XFER_LEN_O,
    output logic START_O,
    output logic EVENT_O,
    output logic EVENT_SHORT_O,
    output logic EVENT_IRQ_O,
    output logic RETIRE_O
);
    import isoch_decode_pkg::*;

    sched_t state_reg;
    logic [31:0] ctrl_reg;
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic [2:0] ev_set;
    logic short_pkt;
    logic bad_len;
    logic [16:0] len_field;

    assign len_field = LEN_DW_I[LEN_HI:0];
    assign bad_len = (len_field > LEN_MAX) || (CTRL_DW_I[INLINE_BIT] && len_field > 17'(INLINE_MAX));
    assign short_pkt = BYTES_DONE_I < XFER_LEN_O;

    // field decode from CTRL_DW_I, registered on the same edge that captures ctrl_reg
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            ctrl_reg <= 32'h0;
            CYCLE_O <= 1'b0;
            EVAL_NEXT_O <= 1'b0;
            SHORT_NOTIFY_O <= 1'b0;
            NOSNOOP_O <= 1'b0;
            CHAIN_O <= 1'b0;
            TD_END_O <= 1'b0;
            COMPL_NOTIFY_O <= 1'b0;
            INLINE_O <= 1'b0;
            INLINE_DATA_O <= 64'h0;
            INLINE_LEN_O <= 4'h0;
            BURSTS_M1_O <= 2'h0;
            LAST_ENTRY_O <= 1'b0;
            SUPPRESS_IRQ_O <= 1'b0;
            TYPE_O <= 6'h0;
            TYPE_OK_O <= 1'b0;
            LAST_BURST_M1_O <= 4'h0;
            FRAME_O <= 11'h0;
            ASAP_O <= 1'b0;
            XFER_LEN_O <= 17'h0;
        end else if (DW_VALID_I) begin
            ctrl_reg <= CTRL_DW_I;
            CYCLE_O <= CTRL_DW_I[CYCLE_BIT];
            EVAL_NEXT_O <= CTRL_DW_I[EVAL_BIT];
            SHORT_NOTIFY_O <= CTRL_DW_I[SPN_BIT];
            NOSNOOP_O <= CTRL_DW_I[SNOOP_BIT] & CFG_NOSNOOP_EN_I;
            CHAIN_O <= CTRL_DW_I[CHAIN_BIT];
            TD_END_O <= ~CTRL_DW_I[CHAIN_BIT];
            COMPL_NOTIFY_O <= CTRL_DW_I[CN_BIT];
            INLINE_O <= CTRL_DW_I[INLINE_BIT];
            INLINE_DATA_O <= CTRL_DW_I[INLINE_BIT] ? PTR_I : 64'h0;
            INLINE_LEN_O <= CTRL_DW_I[INLINE_BIT] && len_field <= 17'(INLINE_MAX) ? len_field[3:0] : 4'h0;
            BURSTS_M1_O <= EXT_COUNT_EN_I ? 2'h0 : CTRL_DW_I[BURST_HI:BURST_LO];
            LAST_ENTRY_O <= STATUS_EN_I && STATUS_CAP_I
                && CTRL_DW_I[BURST_HI:BURST_LO] == LAST_ENTRY_MARK;
            SUPPRESS_IRQ_O <= CTRL_DW_I[SUPP_BIT];
            TYPE_O <= CTRL_DW_I[TYPE_HI:TYPE_LO];
            TYPE_OK_O <= CTRL_DW_I[TYPE_HI:TYPE_LO] == ISOCH_TYPE;
            LAST_BURST_M1_O <= CTRL_DW_I[LBP_HI:LBP_LO];
            FRAME_O <= CTRL_DW_I[FRAME_HI:FRAME_LO];
            ASAP_O <= CTRL_DW_I[ASAP_BIT];
            XFER_LEN_O <= len_field;
        end
    end

    // scheduling: asap starts at once, else waits for frame match
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            state_reg <= ST_IDLE;
            START_O <= 1'b0;
        end else begin
            START_O <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (DW_VALID_I) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (ASAP_O || FRAME_O == MICROFRAME_INDEX_REG_I[MFI_HI:MFI_LO]) begin
                        START_O <= 1'b1;
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (XFER_DONE_I) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // completion and short-packet events, at most one per completion, only when completion or short notify applies
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            EVENT_O <= 1'b0;
            EVENT_SHORT_O <= 1'b0;
            EVENT_IRQ_O <= 1'b0;
            RETIRE_O <= 1'b0;
        end else begin
            RETIRE_O <= XFER_DONE_I && state_reg == ST_RUN;
            EVENT_O <= XFER_DONE_I && state_reg == ST_RUN
                && (COMPL_NOTIFY_O || (SHORT_NOTIFY_O && short_pkt));
            EVENT_SHORT_O <= XFER_DONE_I && state_reg == ST_RUN && short_pkt
                && (SHORT_NOTIFY_O || COMPL_NOTIFY_O);
            EVENT_IRQ_O <= XFER_DONE_I && state_reg == ST_RUN
                && ((COMPL_NOTIFY_O && !SUPPRESS_IRQ_O) || (SHORT_NOTIFY_O && short_pkt));
        end
    end

    assign ev_set[IRQ_SHORT] = XFER_DONE_I && state_reg == ST_RUN && short_pkt;
    assign ev_set[IRQ_DONE] = XFER_DONE_I && state_reg == ST_RUN;
    assign ev_set[IRQ_BAD] = DW_VALID_I && (CTRL_DW_I[TYPE_HI:TYPE_LO] != ISOCH_TYPE || bad_len);

    // sticky status, write one to clear, set wins
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            status_reg <= IRQ_RESET;
            mask_reg <= IRQ_RESET;
        end else begin
            status_reg <= (status_reg & ~((REG_WR_I && REG_ADDR_I == ADDR_STATUS) ? REG_WDATA_I[2:0] : 3'h0))
                | ev_set;
            if (REG_WR_I && REG_ADDR_I == ADDR_MASK) begin
                mask_reg <= REG_WDATA_I[2:0];
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            IRQ_O <= 1'b0;
            REG_RDATA_O <= 32'h0;
        end else begin
            IRQ_O <= |(status_reg & mask_reg);
            if (REG_RD_I) begin
                case (REG_ADDR_I)
                    ADDR_STATUS: REG_RDATA_O <= {29'h0, status_reg};
                    ADDR_MASK: REG_RDATA_O <= {29'h0, mask_reg};
                    ADDR_STATE: REG_RDATA_O <= ctrl_reg;
                    default: REG_RDATA_O <= 32'h0;
                endcase
            end else begin
                REG_RDATA_O <= 32'h0;
            end
        end
    end

    property p_nosnoop;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I && !(CTRL_DW_I[SNOOP_BIT] && CFG_NOSNOOP_EN_I) |=> !NOSNOOP_O;
    endproperty
    a_nosnoop: assert property (p_nosnoop) else $error("no snoop without permission");

    property p_end;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I |=> TD_END_O == !$past(CTRL_DW_I[CHAIN_BIT]);
    endproperty
    a_end: assert property (p_end) else $error("descriptor end wrong");

    property p_asap;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        state_reg == ST_WAIT && ASAP_O |=> START_O;
    endproperty
    a_asap: assert property (p_asap) else $error("asap start missing");

    property p_frame;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        state_reg == ST_WAIT && !ASAP_O && FRAME_O != MICROFRAME_INDEX_REG_I[MFI_HI:MFI_LO] |=> !START_O;
    endproperty
    a_frame: assert property (p_frame) else $error("start before frame match");

    property p_one_event;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        EVENT_O |=> !EVENT_O;
    endproperty
    a_one_event: assert property (p_one_event) else $error("duplicate event");

    property p_supp;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        EVENT_IRQ_O && !EVENT_SHORT_O |-> !SUPPRESS_IRQ_O;
    endproperty
    a_supp: assert property (p_supp) else $error("suppressed interrupt raised");

    property p_done;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        XFER_DONE_I && state_reg == ST_RUN && COMPL_NOTIFY_O |=> EVENT_O && RETIRE_O;
    endproperty
    a_done: assert property (p_done) else $error("completion event missing");

    property p_short;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        XFER_DONE_I && state_reg == ST_RUN && short_pkt && SHORT_NOTIFY_O |=> EVENT_O && EVENT_SHORT_O;
    endproperty
    a_short: assert property (p_short) else $error("short event missing");

    property p_lbp;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I |=> LAST_BURST_M1_O == $past(CTRL_DW_I[LBP_HI:LBP_LO]);
    endproperty
    a_lbp: assert property (p_lbp) else $error("last burst field wrong");

    property p_cycle;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I |=> CYCLE_O == $past(CTRL_DW_I[CYCLE_BIT]);
    endproperty
    a_cycle: assert property (p_cycle) else $error("cycle marker wrong");

    property p_eval;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I |=> EVAL_NEXT_O == $past(CTRL_DW_I[EVAL_BIT]);
    endproperty
    a_eval: assert property (p_eval) else $error("evaluate next flag wrong");

    property p_retire_short;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        XFER_DONE_I && state_reg == ST_RUN && short_pkt |=> RETIRE_O && state_reg == ST_IDLE;
    endproperty
    a_retire_short: assert property (p_retire_short) else $error("short packet not retired");

    property p_evshort;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        EVENT_SHORT_O |-> EVENT_O;
    endproperty
    a_evshort: assert property (p_evshort) else $error("short status outside the single event");

    property p_inline;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I && CTRL_DW_I[INLINE_BIT] |=> INLINE_O && INLINE_DATA_O == $past(PTR_I);
    endproperty
    a_inline: assert property (p_inline) else $error("inline data not passed");

    property p_inline_off;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I && !CTRL_DW_I[INLINE_BIT] |=> !INLINE_O && INLINE_DATA_O == 64'h0 && INLINE_LEN_O == 4'h0;
    endproperty
    a_inline_off: assert property (p_inline_off) else $error("inline fields without inline flag");

    property p_burst_ext;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I && EXT_COUNT_EN_I |=> BURSTS_M1_O == 2'h0;
    endproperty
    a_burst_ext: assert property (p_burst_ext) else $error("burst count used with extended count");

    property p_burst;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I && !EXT_COUNT_EN_I |=> BURSTS_M1_O == $past(CTRL_DW_I[BURST_HI:BURST_LO]);
    endproperty
    a_burst: assert property (p_burst) else $error("burst count wrong");

    property p_last;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I |=> LAST_ENTRY_O == ($past(STATUS_EN_I) && $past(STATUS_CAP_I)
            && $past(CTRL_DW_I[BURST_HI:BURST_LO]) == LAST_ENTRY_MARK);
    endproperty
    a_last: assert property (p_last) else $error("last entry mark wrong");

    property p_type;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I |=> TYPE_O == $past(CTRL_DW_I[TYPE_HI:TYPE_LO]) && TYPE_OK_O == (TYPE_O == ISOCH_TYPE);
    endproperty
    a_type: assert property (p_type) else $error("entry type decode wrong");

    property p_len;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I |=> XFER_LEN_O == $past(LEN_DW_I[LEN_HI:0]);
    endproperty
    a_len: assert property (p_len) else $error("transfer length wrong");

    property p_frame_field;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        DW_VALID_I |=> FRAME_O == $past(CTRL_DW_I[FRAME_HI:FRAME_LO]) && ASAP_O == $past(CTRL_DW_I[ASAP_BIT]);
    endproperty
    a_frame_field: assert property (p_frame_field) else $error("frame or asap field wrong");

    property p_match;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        state_reg == ST_WAIT && FRAME_O == MICROFRAME_INDEX_REG_I[MFI_HI:MFI_LO] |=> START_O;
    endproperty
    a_match: assert property (p_match) else $error("frame match start missing");

    property p_supp_event;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        XFER_DONE_I && state_reg == ST_RUN && COMPL_NOTIFY_O && SUPPRESS_IRQ_O && !(SHORT_NOTIFY_O && short_pkt)
            |=> EVENT_O && !EVENT_IRQ_O;
    endproperty
    a_supp_event: assert property (p_supp_event) else $error("suppressed completion wrong");

    property p_irq_hi;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        |(status_reg & mask_reg) |=> IRQ_O;
    endproperty
    a_irq_hi: assert property (p_irq_hi) else $error("interrupt missing");

    property p_irq_lo;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        (status_reg & mask_reg) == 3'h0 |=> !IRQ_O;
    endproperty
    a_irq_lo: assert property (p_irq_lo) else $error("interrupt without masked status");

    property p_sticky;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        ev_set != 3'h0 |=> (status_reg & $past(ev_set)) == $past(ev_set);
    endproperty
    a_sticky: assert property (p_sticky) else $error("status event lost");

    c_asap: cover property (@(posedge MCLK_I) START_O && ASAP_O);
    c_frame: cover property (@(posedge MCLK_I) START_O && !ASAP_O);
    c_short: cover property (@(posedge MCLK_I) EVENT_SHORT_O);
    c_irq: cover property (@(posedge MCLK_I) IRQ_O);
    c_bad: cover property (@(posedge MCLK_I) status_reg[IRQ_BAD]);
endmodule : isoch_transfer_descriptor_decode
